// ---- rtl/muxed_parallel_memory_port.sv ----
// Multiplexed address/data parallel port with an AXI4-Lite register slave.
// Assumes aclk is the core clock and the external memory meets its own setup and hold.
// Summary of operation
// - Wait a core cycle after latch strobe deasserts
// - Drive address well before latch strobe deasserts
// - Hold address after latch strobe deasserts
// - Reads release data lines after address hold
// - Strobe lasts duration field core cycles, or one cycle when the field is zero
// - Hold option adds one extra hold cycle
// - Byte reads keep upper address through hold
// - Byte reads capture low lines at strobe rise
// - Byte writes drive upper address before strobe
// - Byte writes drive data for whole strobe
// - Wide writes hold data after strobe rises
// - Latch strobe is active high after reset
// - Software may make latch strobe active low
`timescale 1ns/1ps
`default_nettype none
module muxed_parallel_memory_port (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [mport_pkg::REG_AW-1:0] awaddr,
    input wire logic [2:0] awprot,
    // AXI4-Lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [mport_pkg::REG_AW-1:0] araddr,
    input wire logic [2:0] arprot,
    // AXI4-Lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Multiplexed address/data lines
    input wire logic [mport_pkg::PIN_W-1:0] ad_i,
    output logic [mport_pkg::PIN_W-1:0] ad_o,
    output logic [mport_pkg::PIN_W-1:0] ad_oe,
    // Strobes
    output logic ale,
    output logic rd_n,
    output logic wr_n
);
    import mport_pkg::*;

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                                input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // A zero duration would never expire the timer, so it is treated as one cycle
    function automatic logic [CNT_W-1:0] strobe_cycles(input logic [DUR_W-1:0] dur);
        logic [CNT_W-1:0] n;
        n = CNT_W'(dur);
        if (n < MIN_STROBE_CYCLES) begin
            n = MIN_STROBE_CYCLES;
        end
        return n;
    endfunction

    phase_timer_if tmr ();

    phase_timer u_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .tmr(tmr)
    );

    // Registers
    logic [7:0] ctrl_q;
    logic [PIN_W-1:0] addr_q;
    logic [PIN_W-1:0] wdat_q;
    logic [PIN_W-1:0] rdat_q;
    logic write_q;
    logic done_q;
    logic busy;
    logic wide;
    logic [CNT_W-1:0] hold_cycles;

    // Bus slave state
    logic aw_held_q;
    logic w_held_q;
    logic [REG_AW-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic do_write;
    logic start;
    logic done_clr;

    // Sequencer
    seq_state_type state_q;
    seq_state_type state_d;
    logic [PIN_W-1:0] ad_o_d;
    logic [PIN_W-1:0] ad_oe_d;

    assign busy = (state_q != ST_IDLE);
    assign wide = ctrl_q[CTRL_WIDE_BIT];
    assign hold_cycles = ctrl_q[CTRL_HOLD_BIT] ? HOLD_BASE_CYCLES + HOLD_EXTRA_CYCLES
                                               : HOLD_BASE_CYCLES;
    assign do_write = aw_held_q && w_held_q && !bvalid;
    assign start = do_write && (awaddr_q == CMD_OFS) && wstrb_q[0] && wdata_q[CMD_START_BIT] && !busy;
    assign done_clr = do_write && (awaddr_q == STAT_OFS) && wstrb_q[0] && wdata_q[STAT_DONE_BIT];

    // Write address and data are taken independently and paired here
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            awready <= 1'b0;
            awaddr_q <= '0;
        end else if (awvalid && awready) begin
            aw_held_q <= 1'b1;
            awready <= 1'b0;
            awaddr_q <= awaddr;
        end else if (do_write) begin
            aw_held_q <= 1'b0;
            awready <= 1'b1;
        end else if (!aw_held_q) begin
            awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_q <= 1'b0;
            wready <= 1'b0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else if (wvalid && wready) begin
            w_held_q <= 1'b1;
            wready <= 1'b0;
            wdata_q <= wdata;
            wstrb_q <= wstrb;
        end else if (do_write) begin
            w_held_q <= 1'b0;
            wready <= 1'b1;
        end else if (!w_held_q) begin
            wready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (do_write) begin
            bvalid <= 1'b1;
            if (awaddr_q == CTRL_OFS || awaddr_q == ADDR_OFS || awaddr_q == WDATA_OFS
                || awaddr_q == CMD_OFS || awaddr_q == STAT_OFS || awaddr_q == RDATA_OFS) begin
                bresp <= RESP_OKAY;
            end else begin
                bresp <= RESP_SLVERR;
            end
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // Settings are only taken while idle so a running access is never disturbed
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= CTRL_RESET;
            addr_q <= '0;
            wdat_q <= '0;
            write_q <= 1'b0;
        end else if (do_write && !busy) begin
            if (awaddr_q == CTRL_OFS) begin
                ctrl_q <= 8'(merge_bytes(32'(ctrl_q), wdata_q, wstrb_q));
            end else if (awaddr_q == ADDR_OFS) begin
                addr_q <= PIN_W'(merge_bytes(32'(addr_q), wdata_q, wstrb_q));
            end else if (awaddr_q == WDATA_OFS) begin
                wdat_q <= PIN_W'(merge_bytes(32'(wdat_q), wdata_q, wstrb_q));
            end else if (start) begin
                write_q <= wdata_q[CMD_WRITE_BIT];
            end
        end
    end

    // A finish in the same cycle as a clear leaves the flag set
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done_q <= 1'b0;
        end else if (state_q == ST_HOLD && tmr.expired) begin
            done_q <= 1'b1;
        end else if (done_clr || start) begin
            done_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rresp <= RESP_OKAY;
            if (araddr == CTRL_OFS) begin
                rdata <= 32'(ctrl_q);
            end else if (araddr == ADDR_OFS) begin
                rdata <= 32'(addr_q);
            end else if (araddr == WDATA_OFS) begin
                rdata <= 32'(wdat_q);
            end else if (araddr == CMD_OFS) begin
                rdata <= 32'(write_q) << CMD_WRITE_BIT;
            end else if (araddr == STAT_OFS) begin
                rdata <= (32'(done_q) << STAT_DONE_BIT) | (32'(busy) << STAT_BUSY_BIT);
            end else if (araddr == RDATA_OFS) begin
                rdata <= 32'(rdat_q);
            end else begin
                rdata <= '0;
                rresp <= RESP_SLVERR;
            end
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end else if (!rvalid) begin
            arready <= 1'b1;
        end
    end

    // Phase sequencing; the timer is reloaded on every state change except the return to idle
    always_comb begin
        state_d = state_q;
        tmr.load = 1'b0;
        tmr.load_val = '0;
        case (state_q)
            ST_IDLE: begin
                if (start) begin
                    state_d = ST_SETUP;
                    tmr.load = 1'b1;
                    tmr.load_val = SETUP_CYCLES;
                end
            end
            ST_SETUP: begin
                if (tmr.expired) begin
                    state_d = ST_ALE;
                    tmr.load = 1'b1;
                    tmr.load_val = ALE_CYCLES;
                end
            end
            ST_ALE: begin
                if (tmr.expired) begin
                    state_d = ST_AHOLD;
                    tmr.load = 1'b1;
                    tmr.load_val = AHOLD_CYCLES;
                end
            end
            ST_AHOLD: begin
                if (tmr.expired) begin
                    state_d = ST_STROBE;
                    tmr.load = 1'b1;
                    tmr.load_val = strobe_cycles(ctrl_q[DUR_MSB:DUR_LSB]);
                end
            end
            ST_STROBE: begin
                if (tmr.expired) begin
                    state_d = ST_HOLD;
                    tmr.load = 1'b1;
                    tmr.load_val = hold_cycles;
                end
            end
            ST_HOLD: begin
                if (tmr.expired) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Line drive for the coming cycle, chosen from the next state
    always_comb begin
        ad_o_d = addr_q;
        ad_oe_d = '0;
        case (state_d)
            ST_SETUP, ST_ALE, ST_AHOLD: begin
                ad_oe_d = ALL_MASK;
            end
            ST_STROBE, ST_HOLD: begin
                if (write_q) begin
                    ad_oe_d = ALL_MASK;
                    if (wide) begin
                        ad_o_d = wdat_q;
                    end else begin
                        ad_o_d = (addr_q & UPPER_MASK) | (wdat_q & ~UPPER_MASK);
                    end
                end else begin
                    ad_oe_d = wide ? '0 : UPPER_MASK;
                end
            end
            default: begin
                ad_oe_d = '0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ad_o <= '0;
            ad_oe <= '0;
            ale <= 1'b0;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
        end else begin
            ad_o <= ad_o_d;
            ad_oe <= ad_oe_d;
            ale <= (state_d == ST_ALE) ^ ctrl_q[CTRL_ALE_LOW_BIT];
            rd_n <= !(state_d == ST_STROBE && !write_q);
            wr_n <= !(state_d == ST_STROBE && write_q);
        end
    end

    // Sampled on the edge that raises the read strobe; the memory keeps data up to it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rdat_q <= '0;
        end else if (state_q == ST_STROBE && tmr.expired && !write_q) begin
            if (wide) begin
                rdat_q <= ad_i;
            end else begin
                rdat_q <= ad_i & ~UPPER_MASK;
            end
        end
    end
endmodule
`default_nettype wire

// ---- rtl/mport_pkg.sv ----
// Constants, register map and types for the multiplexed parallel memory port.
// Assumes the port runs on the core clock; all pin timing is in whole core cycles.
package mport_pkg;
    localparam int unsigned REG_AW = 8;
    localparam int unsigned PIN_W = 16;
    localparam int unsigned CNT_W = 6;
    localparam int unsigned DUR_W = 5;

    // Register byte offsets
    localparam logic [REG_AW-1:0] CTRL_OFS = 8'h00;
    localparam logic [REG_AW-1:0] ADDR_OFS = 8'h04;
    localparam logic [REG_AW-1:0] WDATA_OFS = 8'h08;
    localparam logic [REG_AW-1:0] CMD_OFS = 8'h0c;
    localparam logic [REG_AW-1:0] STAT_OFS = 8'h10;
    localparam logic [REG_AW-1:0] RDATA_OFS = 8'h14;

    // Port control register fields
    localparam int unsigned CTRL_WIDE_BIT = 0;
    localparam int unsigned DUR_LSB = 1;
    localparam int unsigned DUR_MSB = 5;
    localparam int unsigned CTRL_HOLD_BIT = 6;
    localparam int unsigned CTRL_ALE_LOW_BIT = 7;
    localparam logic [7:0] CTRL_RESET = 8'h02;

    localparam int unsigned CMD_START_BIT = 0;
    localparam int unsigned CMD_WRITE_BIT = 1;
    localparam int unsigned STAT_BUSY_BIT = 0;
    localparam int unsigned STAT_DONE_BIT = 1;

    // Timing, in core clock periods (setup and hold kept in tenths)
    localparam int unsigned ALE_WIDTH_TCCLK = 2;
    localparam int unsigned ADDR_SETUP_TCCLK_X10 = 25;
    localparam int unsigned ALE_TO_STROBE_TCCLK = 1;
    localparam int unsigned STROBE_HOLD_TCCLK_X10 = 5;
    localparam int unsigned HOLD_CYCLE_TCCLK = 1;

    localparam logic [CNT_W-1:0] ALE_CYCLES = CNT_W'(ALE_WIDTH_TCCLK);
    localparam logic [CNT_W-1:0] SETUP_CYCLES = CNT_W'((ADDR_SETUP_TCCLK_X10 + 9) / 10 - ALE_WIDTH_TCCLK);
    localparam logic [CNT_W-1:0] AHOLD_CYCLES = CNT_W'(ALE_TO_STROBE_TCCLK);
    localparam logic [CNT_W-1:0] HOLD_BASE_CYCLES = CNT_W'((STROBE_HOLD_TCCLK_X10 + 9) / 10);
    localparam logic [CNT_W-1:0] HOLD_EXTRA_CYCLES = CNT_W'(HOLD_CYCLE_TCCLK);
    localparam logic [CNT_W-1:0] MIN_STROBE_CYCLES = 6'h01;

    localparam logic [PIN_W-1:0] UPPER_MASK = 16'hff00;
    localparam logic [PIN_W-1:0] ALL_MASK = 16'hffff;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETUP = 3'b001,
        ST_ALE = 3'b010,
        ST_AHOLD = 3'b011,
        ST_STROBE = 3'b100,
        ST_HOLD = 3'b101
    } seq_state_type;
endpackage

// ---- rtl/phase_timer_if.sv ----
// Carrier between the sequencer and its phase timer.
// Assumes both ends share aclk.
`timescale 1ns/1ps
`default_nettype none
interface phase_timer_if;
    import mport_pkg::*;
    logic load;
    logic [CNT_W-1:0] load_val;
    logic expired;
    modport ctl (output load, output load_val, input expired);
    modport cnt (input load, input load_val, output expired);
endinterface
`default_nettype wire

// ---- rtl/phase_timer.sv ----
// Down counter that measures the length of one bus phase.
// Assumes load values of at least one; expired marks the last cycle of the phase.
`timescale 1ns/1ps
`default_nettype none
module phase_timer (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Sequencer side
    phase_timer_if.cnt tmr
);
    import mport_pkg::*;

    logic [CNT_W-1:0] count_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_q <= '0;
        end else if (tmr.load) begin
            count_q <= tmr.load_val;
        end else if (count_q != '0) begin
            count_q <= count_q - 1'b1;
        end
    end

    assign tmr.expired = (count_q == MIN_STROBE_CYCLES);
endmodule
`default_nettype wire

// ---- verification/mport_chk.sv ----
// Pin-level timing checks for the multiplexed memory port.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module mport_chk (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Muxed lines and strobes
    input wire logic [mport_pkg::PIN_W-1:0] ad_o,
    input wire logic [mport_pkg::PIN_W-1:0] ad_oe,
    input wire logic ale,
    input wire logic rd_n,
    input wire logic wr_n
);
    import mport_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Polarity is unknown here, so the latch pulse is judged by level changes only
    chk_ale_sequence: assert property (
        $fell(rd_n && wr_n) |-> ale == $past(ale, 1) && ale != $past(ale, 2)
        && $past(ale, 2) == $past(ale, 3) && $past(ale, 4) == ale) else $error("latch pulse shape wrong");
    chk_addr_setup: assert property (
        $fell(rd_n && wr_n) |-> ($past(ad_oe, 4) & $past(ad_oe, 2)) == 16'hffff
        && $past(ad_o, 4) == $past(ad_o, 2)) else $error("address not set up before latch");
    chk_addr_hold: assert property (
        $fell(rd_n && wr_n) |-> $past(ad_oe, 1) == 16'hffff && $past(ad_o, 1) == $past(ad_o, 2))
        else $error("address not held after latch");
    chk_rd_release: assert property (
        $fell(rd_n) |-> ad_oe == 16'h0000 || ad_oe == 16'hff00) else $error("lines not released for read");
    chk_rd_upper_hold: assert property (
        $rose(rd_n) && ad_oe[15] |-> ad_oe[15:8] == 8'hff && $stable(ad_o[15:8]))
        else $error("upper address dropped at read end");
    chk_wr_stable: assert property (
        !wr_n && $past(!wr_n) |-> $stable(ad_o) && ad_oe == 16'hffff) else $error("write data moved");
    chk_wr_hold: assert property (
        $rose(wr_n) |-> $stable(ad_o) && ad_oe == 16'hffff) else $error("write data not held");
    chk_wr_upper_setup: assert property (
        $fell(wr_n) |-> $past(ad_oe[15:8], 1) == 8'hff) else $error("upper address late for write");
    chk_strobe_excl: assert property (
        !(!rd_n && !wr_n)) else $error("both strobes low");
    chk_ale_reset: assert property (
        disable iff (1'b0) !aresetn |=> !ale) else $error("latch strobe not idle low after reset");
endmodule
bind muxed_parallel_memory_port mport_chk u_chk (.aclk(aclk), .aresetn(aresetn), .ad_o(ad_o), .ad_oe(ad_oe),
    .ale(ale), .rd_n(rd_n), .wr_n(wr_n));
`default_nettype wire

// ---- verification/mport_mem_model.sv ----
// Asynchronous memory with address latch on the far side of the port.
// Assumes the bench mirrors the width and latch polarity settings.
`timescale 1ns/1ps
`default_nettype none
module mport_mem_model (
    // Clock
    input wire logic aclk,
    // Port pins
    input wire logic [15:0] ad_o,
    input wire logic [15:0] ad_oe,
    input wire logic ale,
    input wire logic rd_n,
    input wire logic wr_n,
    // Mirrored settings
    input wire logic ale_low,
    input wire logic wide,
    output logic [15:0] ad_i
);
    logic [15:0] mem [0:65535];
    logic [15:0] lat_q = 16'h0000;
    logic [15:0] rel_q = 16'h0000;
    logic [15:0] word_q = 16'h0000;
    logic [15:0] key;
    logic wr_q = 1'b1;
    // Unwritten words read as a scramble of their address
    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 16'(i) ^ 16'h5a3c;
        end
    end
    assign key = wide ? lat_q : {ad_o[15:8], lat_q[7:0]};
    // Released lines toggle so a stale value can never look right
    assign ad_i = (ad_oe & ad_o) | (~ad_oe & (rd_n ? rel_q : word_q));
    always @(posedge aclk) begin
        rel_q <= ~rel_q;
        wr_q <= wr_n;
        if (ale ^ ale_low) lat_q <= ad_o;
        word_q <= mem[key];
        if (!wr_q && wr_n) mem[key] <= wide ? ad_o : {8'h00, ad_o[7:0]};
    end
endmodule
`default_nettype wire

// ---- verification/muxed_parallel_memory_port_tb.sv ----
// Self-checking bench for the multiplexed memory port.
// Assumes the memory model answers on the far side of the muxed lines.
`timescale 1ns/1ps
`default_nettype none
module muxed_parallel_memory_port_tb;
    import mport_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [REG_AW-1:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic awready, wready, bvalid, arready, rvalid, ale, rd_n, wr_n;
    logic ale_low = 1'b0, wide = 1'b0, st_q = 1'b1;
    logic [1:0] bresp, rresp;
    logic [15:0] ad_i, ad_o, ad_oe;
    logic [5:0] lo_n = 6'h00, ho_n = 6'h00;
    int fails = 0, n_compared = 0;
    always #2.5 aclk = ~aclk;
    muxed_parallel_memory_port DUT (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf),
        .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
        .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .ad_i(ad_i), .ad_o(ad_o), .ad_oe(ad_oe), .ale(ale), .rd_n(rd_n), .wr_n(wr_n));
    mport_mem_model u_mem (.aclk(aclk), .ad_o(ad_o), .ad_oe(ad_oe), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
        .ale_low(ale_low), .wide(wide), .ad_i(ad_i));
    // Strobe length and post-strobe drive length of the latest access
    always @(posedge aclk) begin
        st_q <= rd_n & wr_n;
        if (!(rd_n & wr_n)) begin
            lo_n <= st_q ? 6'h01 : lo_n + 6'h01;
            ho_n <= 6'h00;
        end else if (ad_oe != 16'h0000) begin
            ho_n <= ho_n + 6'h01;
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Pending flags are blocking so the loop never reads a pending flag before its update lands
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_p;
        logic w_p;
        logic b_p;
        aw_p = 1'b1;
        w_p = 1'b1;
        b_p = 1'b1;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (aw_p || w_p || b_p) begin
            @(posedge aclk);
            if (aw_p && awready) begin
                aw_p = 1'b0;
                awvalid <= 1'b0;
            end
            if (w_p && wready) begin
                w_p = 1'b0;
                wvalid <= 1'b0;
            end
            if (b_p && bvalid) begin
                b_p = 1'b0;
                r = bresp;
                bready <= 1'b0;
            end
        end
        // One idle edge so a following call never re-raises a valid or ready in the same step
        @(posedge aclk);
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_p;
        logic r_p;
        ar_p = 1'b1;
        r_p = 1'b1;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (ar_p || r_p) begin
            @(posedge aclk);
            if (ar_p && arready) begin
                ar_p = 1'b0;
                arvalid <= 1'b0;
            end
            if (r_p && rvalid) begin
                r_p = 1'b0;
                d = rdata;
                r = rresp;
                rready <= 1'b0;
            end
        end
        @(posedge aclk);
    endtask
    task automatic wait_idle;
        logic [31:0] v;
        logic [1:0] r;
        int k;
        v = 32'h1;
        k = 0;
        while (v[0] && k < 60) begin
            axi_rd(STAT_OFS, v, r);
            k++;
        end
        check(32'(v[1:0]), 32'h2);
    endtask
    task automatic t_regs;
        logic [31:0] v;
        logic [1:0] r;
        check(32'(ale), 32'h0);
        axi_rd(CTRL_OFS, v, r);
        check(v, 32'(CTRL_RESET));
        axi_rd(8'h18, v, r);
        check({30'h0, r}, {30'h0, RESP_SLVERR});
        check(v, 32'h0);
        axi_wr(8'h18, 32'h1, r);
        check({30'h0, r}, {30'h0, RESP_SLVERR});
    endtask
    task automatic t_access(input logic [7:0] c, input logic [15:0] a, input logic [15:0] d,
                            input logic w, input logic [31:0] e);
        logic [31:0] v;
        logic [1:0] r;
        ale_low <= c[7];
        wide <= c[0];
        axi_wr(CTRL_OFS, {24'h0, c}, r);
        check(32'(ale), 32'(c[7]));
        axi_wr(ADDR_OFS, {16'h0, a}, r);
        axi_wr(WDATA_OFS, {16'h0, d}, r);
        axi_wr(CMD_OFS, {30'h0, w, 1'b1}, r);
        wait_idle();
        check(32'(lo_n), (c[5:1] == 5'h00) ? 32'h1 : 32'(c[5:1]));
        check(32'(ho_n), (w || !c[0]) ? 32'h1 + 32'(c[6]) : 32'h0);
        if (!w) begin
            axi_rd(RDATA_OFS, v, r);
            check(v, e);
        end
    endtask
    // Settings written mid-access must be dropped, not queued
    task automatic t_busy;
        logic [31:0] v;
        logic [1:0] r;
        ale_low <= 1'b0;
        wide <= 1'b0;
        axi_wr(CTRL_OFS, 32'h3e, r);
        axi_wr(CMD_OFS, 32'h1, r);
        axi_wr(CTRL_OFS, 32'h81, r);
        check({30'h0, r}, {30'h0, RESP_OKAY});
        wait_idle();
        axi_rd(CTRL_OFS, v, r);
        check(v, 32'h3e);
    endtask
    task automatic complete_run;
        $display("Compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #200000;
        fails++;
        complete_run();
    end
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        t_access(8'h07, 16'h1234, 16'hbeef, 1'b1, 32'h0);
        t_access(8'h47, 16'h1234, 16'h0000, 1'b0, 32'hbeef);
        t_access(8'h42, 16'ha5c3, 16'h127e, 1'b1, 32'h0);
        t_access(8'h00, 16'ha5c3, 16'h0000, 1'b0, 32'h7e);
        t_access(8'hbf, 16'h0f0f, 16'h0000, 1'b0, 32'h5533);
        t_access(8'h84, 16'h00ff, 16'h3399, 1'b1, 32'h0);
        t_access(8'h04, 16'h00ff, 16'h0000, 1'b0, 32'h99);
        t_busy();
        complete_run();
    end
endmodule
`default_nettype wire
